// ### src/lfs_fault_cell.sv
/*
  One fault flag: sticky set with clear, or a plain level follower.
  Assumes set and clear are already qualified by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module lfs_fault_cell #(
  parameter bit LEVEL = 1'b0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic set,
  input wire logic clear,
  output logic flag
);

  logic next_flag;

  // Set wins over a clear in the same cycle
  assign next_flag = LEVEL ? set : (set | (flag & ~clear));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : lfs_fault_cell
`default_nettype wire

// ### src/lfs_fault_status.sv
/*
  Status/control and fault word bank of the laser current driver.
  Host commands arrive decoded on a one-cycle command strobe; monitor
  events come from on-chip logic on clk; the enable pin is asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module lfs_fault_status
  import lfs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  // Host command port
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [31:0] cmd_wdata,
  output logic resp_valid,
  output logic [63:0] resp_data,
  // Breakout connector enable pin
  input wire logic ext_enable_pin,
  // Monitor events, same clock domain
  input wire logic selftest_active,
  input wire logic stage_overheat,
  input wire logic load_failure,
  input wire logic overcurrent,
  input wire logic supply_out_of_range,
  input wire logic handheld_image_bad,
  input wire logic defaults_check_bad,
  input wire logic config_check_bad,
  input wire logic calibration_check_bad,
  input wire logic settings_load_failed,
  input wire logic temp_above_max,
  input wire logic cooling_down,
  input wire logic temp_near_limit,
  input wire logic regulator_saturated,
  input wire logic current_out_of_range,
  // Outputs to regulation and host link
  output logic current_output_on,
  output logic ext_setpoint_range_select,
  output logic external_enable_select,
  output logic ext_setpoint_use,
  output logic image_download_allowed
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detect

  logic pin_s;
  logic pin_d;
  logic pin_rise;

  // Pin is asynchronous to clk; only the second flop is read
  lfs_sync #(
    .WIDTH(1)
  ) u_pin_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(ext_enable_pin),
    .sync_out(pin_s)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_d <= 1'b0;
    end else begin
      pin_d <= pin_s;
    end
  end

  // Both flops reset low, so a pin already high at release reads as a rise
  assign pin_rise = pin_s & ~pin_d;

  ////////////////////////////////////////////////////////////////////////
  // Power-up sampling window

  logic [3:0] pwr_cnt;
  logic [3:0] next_pwr_cnt;
  logic pwr_done;
  logic next_pwr_done;
  logic pwr_sample;

  // One look at the pin only; a later rise is not recorded here
  assign pwr_sample = ~pwr_done && (pwr_cnt == 4'(POWERUP_SAMPLE_CYC - 1));
  assign next_pwr_cnt = pwr_done ? pwr_cnt : pwr_cnt + 4'h1;
  assign next_pwr_done = pwr_done | pwr_sample;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_cnt <= 4'h0;
    end else begin
      pwr_cnt <= next_pwr_cnt;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_done <= 1'b0;
    end else begin
      pwr_done <= next_pwr_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode

  logic [31:0] status;
  logic sw_enable;
  logic [15:0] fault;
  logic cmd_rd_status;
  logic cmd_rd_fault;
  logic cmd_rd_comb;
  logic cmd_wr_status;
  logic cmd_clear;

  // Codes 5 to 7 decode to nothing yet still get a response
  assign cmd_rd_status = cmd_valid && (cmd_code == CMD_READ_STATUS);
  assign cmd_rd_fault = cmd_valid && (cmd_code == CMD_READ_FAULT);
  assign cmd_rd_comb = cmd_valid && (cmd_code == CMD_COMBINED_WORD_READ);
  assign cmd_wr_status = cmd_valid && (cmd_code == CMD_WRITE_STATUS);
  assign cmd_clear = cmd_valid && (cmd_code == CMD_FAULT_CLEAR);

  ////////////////////////////////////////////////////////////////////////
  // Status/control word

  logic ext_sel;
  logic enable_ok_rd;
  logic any_fault;
  logic no_fault;
  logic [31:0] status_rd;
  logic [31:0] next_status;
  logic next_sw_enable;
  logic wr_ext_sel;
  logic ext_sel_switch_on;

  assign ext_sel = status[ST_EXTERNAL_ENABLE_SELECT];
  assign enable_ok_rd = ext_sel ? pin_s : sw_enable;
  assign any_fault = |(fault & FAULT_DEFINED_MASK);
  assign no_fault = ~any_fault;

  always_comb begin
    status_rd = status & STATUS_STORED_MASK;
    status_rd[ST_ENABLE_OK] = enable_ok_rd;
    status_rd[ST_NO_FAULT] = no_fault;
  end

  assign wr_ext_sel = cmd_wdata[ST_EXTERNAL_ENABLE_SELECT];
  assign ext_sel_switch_on = cmd_wr_status & wr_ext_sel & ~ext_sel;

  always_comb begin
    next_status = status;
    next_sw_enable = sw_enable;
    if (cmd_wr_status) begin
      next_status[ST_OUTPUT_ON] = cmd_wdata[ST_OUTPUT_ON];
      next_status[ST_DEFAULTS_AT_POWERUP] = cmd_wdata[ST_DEFAULTS_AT_POWERUP];
      next_status[ST_EXTERNAL_ENABLE_SELECT] = wr_ext_sel;
      next_status[ST_EXT_SETPOINT_RANGE_SELECT] = cmd_wdata[ST_EXT_SETPOINT_RANGE_SELECT];
      // Setpoint source frozen while enabled, avoids a current step
      if (!enable_ok_rd) begin
        next_status[ST_EXT_SETPOINT_USE] = cmd_wdata[ST_EXT_SETPOINT_USE];
      end
      // Bit 2 drives the software enable only while it is the source
      if (!ext_sel) begin
        next_sw_enable = cmd_wdata[ST_ENABLE_OK];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status <= STATUS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // Kept apart from the word; it reads back only while it is the source
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_enable <= 1'b0;
    end else begin
      sw_enable <= next_sw_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault word

  logic [15:0] fault_set;
  logic [15:0] fault_clr;
  logic clear_event;
  logic pin_cycle_clear;

  // Enable cycle counts only while the pin is the selected source
  assign pin_cycle_clear = ext_sel & pin_rise;
  // Clear by command or enable cycle
  assign clear_event = cmd_clear | pin_cycle_clear;
  assign fault_clr = clear_event ? ~FAULT_PERSIST_MASK : 16'h0000;

  // Set inputs come from logic on clk, so no synchroniser here
  always_comb begin
    fault_set = 16'h0000;
    fault_set[F_STAGE_OVERHEAT] = stage_overheat;
    fault_set[F_LOAD_OR_OVERCURRENT] = load_failure | overcurrent;
    fault_set[F_SUPPLY_RANGE] = supply_out_of_range;
    fault_set[F_HANDHELD_IMAGE_CHECK] = handheld_image_bad;
    fault_set[F_DEFAULTS_CHECK] = defaults_check_bad;
    fault_set[F_CONFIG_CHECK] = selftest_active & config_check_bad;
    fault_set[F_CALIBRATION_CHECK] = selftest_active & calibration_check_bad;
    fault_set[F_SETTINGS_LOAD] = settings_load_failed;
    fault_set[F_TEMP_EXCEEDED] = temp_above_max;
    fault_set[F_COOLDOWN_PENDING] = cooling_down;
    fault_set[F_HEAT_NEAR_LIMIT] = temp_near_limit;
    fault_set[F_ENABLE_HIGH_AT_POWERUP] = pwr_sample & pin_s;
    fault_set[F_ENABLE_HIGH_AT_SWITCH] = ext_sel_switch_on & pin_s;
    fault_set[F_REGULATOR_SATURATION] = regulator_saturated;
    fault_set[F_OUTPUT_CURRENT_RANGE] = current_out_of_range;
  end

  genvar gi;
  generate
    for (gi = 0; gi < FAULT_BITS; gi++) begin : g_fault
      if (FAULT_DEFINED_MASK[gi]) begin : g_def
        lfs_fault_cell #(
          .LEVEL(FAULT_LEVEL_MASK[gi])
        ) u_cell (
          .clk(clk),
          .arst_n(arst_n),
          .set(fault_set[gi]),
          .clear(fault_clr[gi]),
          .flag(fault[gi])
        );
      end else begin : g_rsv
        assign fault[gi] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Responses and outputs

  logic [63:0] next_resp;
  logic [31:0] fault_rd;
  logic [31:0] status_after_wr;

  assign fault_rd = {16'h0000, fault};

  // New value echoed back after a status write
  always_comb begin
    status_after_wr = next_status & STATUS_STORED_MASK;
    status_after_wr[ST_ENABLE_OK] = next_status[ST_EXTERNAL_ENABLE_SELECT] ? pin_s
                                                                             : next_sw_enable;
    status_after_wr[ST_NO_FAULT] = no_fault;
  end

  // Codes 4 to 7 answer zero, so stale data never looks valid
  always_comb begin
    next_resp = 64'h0000_0000_0000_0000;
    if (cmd_rd_status) begin
      next_resp = {32'h0000_0000, status_rd};
    end else if (cmd_rd_fault) begin
      next_resp = {32'h0000_0000, fault_rd};
    end else if (cmd_rd_comb) begin
      next_resp = {fault_rd, status_rd};
    end else if (cmd_wr_status) begin
      next_resp = {32'h0000_0000, status_after_wr};
    end
  end

  logic next_output_on;
  logic next_download_allowed;

  assign next_output_on = status[ST_OUTPUT_ON] & enable_ok_rd & ~any_fault;
  assign next_download_allowed = ~fault[F_HANDHELD_IMAGE_CHECK];

  // Reloaded every cycle, so an old answer never lingers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resp_valid <= 1'b0;
      resp_data <= 64'h0000_0000_0000_0000;
    end else begin
      resp_valid <= cmd_valid;
      resp_data <= next_resp;
    end
  end

  // Registered gate: one cycle of lag traded for a clean enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      current_output_on <= 1'b0;
    end else begin
      current_output_on <= next_output_on;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_setpoint_range_select <= 1'b0;
      external_enable_select <= 1'b0;
      ext_setpoint_use <= 1'b0;
    end else begin
      ext_setpoint_range_select <= status[ST_EXT_SETPOINT_RANGE_SELECT];
      external_enable_select <= ext_sel;
      ext_setpoint_use <= status[ST_EXT_SETPOINT_USE];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      image_download_allowed <= 1'b0;
    end else begin
      image_download_allowed <= next_download_allowed;
    end
  end

endmodule : lfs_fault_status
`default_nettype wire

// ### src/lfs_pkg.sv
/*
  Constants for the laser driver status/control and fault word logic:
  bit positions, masks, reset values, command codes and timing counts.
  Assumes a single 10 MHz system clock and a power-on reset.
*/
package lfs_pkg;

  localparam int WORD_W = 32;

  // Status/control word bit positions
  localparam int ST_OUTPUT_ON = 0;
  localparam int ST_EXT_SETPOINT_USE = 1;
  localparam int ST_ENABLE_OK = 2;
  localparam int ST_NO_FAULT = 3;
  localparam int ST_DEFAULTS_AT_POWERUP = 4;
  localparam int ST_EXTERNAL_ENABLE_SELECT = 6;
  localparam int ST_EXT_SETPOINT_RANGE_SELECT = 7;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0001;
  localparam logic [31:0] STATUS_STORED_MASK = 32'h0000_00D7;

  // Fault word bit positions
  localparam int F_STAGE_OVERHEAT = 0;
  localparam int F_LOAD_OR_OVERCURRENT = 1;
  localparam int F_SUPPLY_RANGE = 2;
  localparam int F_HANDHELD_IMAGE_CHECK = 3;
  localparam int F_DEFAULTS_CHECK = 4;
  localparam int F_CONFIG_CHECK = 5;
  localparam int F_CALIBRATION_CHECK = 7;
  localparam int F_SETTINGS_LOAD = 8;
  localparam int F_TEMP_EXCEEDED = 9;
  localparam int F_COOLDOWN_PENDING = 10;
  localparam int F_HEAT_NEAR_LIMIT = 11;
  localparam int F_ENABLE_HIGH_AT_POWERUP = 12;
  localparam int F_ENABLE_HIGH_AT_SWITCH = 13;
  localparam int F_REGULATOR_SATURATION = 14;
  localparam int F_OUTPUT_CURRENT_RANGE = 15;
  localparam int FAULT_BITS = 16;
  localparam logic [15:0] FAULT_RESET = 16'h0000;
  localparam logic [15:0] FAULT_DEFINED_MASK = 16'hFFBF;
  localparam logic [15:0] FAULT_PERSIST_MASK = 16'h00A0;
  localparam logic [15:0] FAULT_LEVEL_MASK = 16'h0400;

  // Command codes on the host command port
  localparam logic [2:0] CMD_READ_STATUS = 3'h0;
  localparam logic [2:0] CMD_READ_FAULT = 3'h1;
  localparam logic [2:0] CMD_COMBINED_WORD_READ = 3'h2;
  localparam logic [2:0] CMD_WRITE_STATUS = 3'h3;
  localparam logic [2:0] CMD_FAULT_CLEAR = 3'h4;

  // Power-up sampling of the enable pin, after the synchroniser settles
  localparam int CLK_HZ = 10_000_000;
  localparam int POWERUP_SAMPLE_NS = 300;
  localparam int POWERUP_SAMPLE_CYC = (POWERUP_SAMPLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

endpackage : lfs_pkg

// ### src/lfs_sync.sv
/*
  Two-flop synchroniser for pin levels.
  Assumes inputs are asynchronous to clk; only the second flop is read.
*/
`timescale 1ns/1ps
`default_nettype none
module lfs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule : lfs_sync
`default_nettype wire

// ### verif/lfs_fault_status_sva.sv
/*
  Port-level checker for lfs_fault_status.
  Bound to every instance; sees only the top module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module lfs_fault_status_sva
  import lfs_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [31:0] cmd_wdata,
  input wire logic resp_valid,
  input wire logic [63:0] resp_data,
  input wire logic selftest_active,
  input wire logic stage_overheat,
  input wire logic load_failure,
  input wire logic overcurrent,
  input wire logic supply_out_of_range,
  input wire logic handheld_image_bad,
  input wire logic defaults_check_bad,
  input wire logic config_check_bad,
  input wire logic calibration_check_bad,
  input wire logic settings_load_failed,
  input wire logic temp_above_max,
  input wire logic cooling_down,
  input wire logic temp_near_limit,
  input wire logic regulator_saturated,
  input wire logic current_out_of_range,
  input wire logic current_output_on,
  input wire logic ext_setpoint_range_select,
  input wire logic external_enable_select,
  input wire logic image_download_allowed
);
  logic seen_cfg;
  logic seen_cal;
  logic any_ev;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  ////////////////////////////////////////////////////////////////////////
  assign any_ev = stage_overheat | load_failure | overcurrent | supply_out_of_range |
    handheld_image_bad | defaults_check_bad | settings_load_failed | temp_above_max |
    cooling_down | temp_near_limit | regulator_saturated | current_out_of_range |
    (selftest_active & (config_check_bad | calibration_check_bad));

  // Only reset clears these, same as the device
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_cfg <= 1'b0;
      seen_cal <= 1'b0;
    end else begin
      seen_cfg <= seen_cfg | (selftest_active & config_check_bad);
      seen_cal <= seen_cal | (selftest_active & calibration_check_bad);
    end
  end

  sequence s_rd;
    cmd_valid && cmd_code == CMD_COMBINED_WORD_READ;
  endsequence
  sequence s_wr_once;
    cmd_valid && cmd_code == CMD_WRITE_STATUS ##1 !(cmd_valid && cmd_code == CMD_WRITE_STATUS);
  endsequence

  ////////////////////////////////////////////////////////////////////////
  a_resp_follows_cmd: assert property (cmd_valid |=> resp_valid)
    else $error("no response one cycle after command");
  a_no_stray_resp: assert property (!cmd_valid |=> !resp_valid)
    else $error("response without command");
  a_fault_forces_off: assert property (any_ev |-> ##2 !current_output_on)
    else $error("output on with fault set");
  a_image_blocked: assert property (handheld_image_bad |-> ##2 !image_download_allowed)
    else $error("download allowed with bad image");
  a_range_copy: assert property (s_wr_once |=>
    ext_setpoint_range_select == $past(cmd_wdata[7], 2))
    else $error("setpoint range select not written");
  a_select_copy: assert property (s_wr_once |=>
    external_enable_select == $past(cmd_wdata[6], 2))
    else $error("enable source select not written");
  a_selftest_persist: assert property (s_rd |=>
    resp_data[37] == $past(seen_cfg) && resp_data[39] == $past(seen_cal))
    else $error("self test fault bits wrong");
  a_cooldown_level: assert property (s_rd |=> resp_data[42] == $past(cooling_down, 2))
    else $error("cooldown bit does not follow input");
  a_reserved_zero: assert property (resp_valid |->
    (($past(cmd_code) == CMD_READ_FAULT) ?
    (resp_data[63:16] == 48'h0000_0000_0000 && !resp_data[6]) :
    (resp_data[63:48] == 16'h0000 && !resp_data[38] && resp_data[31:8] == 24'h00_0000 &&
    !resp_data[5])))
    else $error("reserved bits not zero");
  a_nonread_zero: assert property (cmd_valid && cmd_code >= CMD_FAULT_CLEAR |=>
    resp_data == '0)
    else $error("non-read command returned data");
endmodule : lfs_fault_status_sva

bind lfs_fault_status lfs_fault_status_sva lfs_fault_status_sva_u (.*);
`default_nettype wire

// ### verif/testbench.sv
/*
  Self-checking bench for lfs_fault_status.
  Drives every port directly; 10 MHz clock, fixed random seed.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import lfs_pkg::*;
;
  logic clk, arst_n, cmd_valid, ext_enable_pin, selftest_active, cooling_down;
  logic [2:0] cmd_code;
  logic [31:0] cmd_wdata, wd, pers, f;
  logic [12:0] ev;
  logic resp_valid, current_output_on, ext_setpoint_range_select;
  logic external_enable_select, ext_setpoint_use, image_download_allowed;
  logic [63:0] resp_data, rd;
  int fail_count, samples_checked;
  int fmap[13] = '{0, 1, 1, 2, 3, 4, 5, 7, 8, 9, 11, 14, 15};

  lfs_fault_status dut_u (
    .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .resp_valid(resp_valid), .resp_data(resp_data),
    .ext_enable_pin(ext_enable_pin), .selftest_active(selftest_active),
    .stage_overheat(ev[0]), .load_failure(ev[1]), .overcurrent(ev[2]),
    .supply_out_of_range(ev[3]), .handheld_image_bad(ev[4]), .defaults_check_bad(ev[5]),
    .config_check_bad(ev[6]), .calibration_check_bad(ev[7]), .settings_load_failed(ev[8]),
    .temp_above_max(ev[9]), .cooling_down(cooling_down), .temp_near_limit(ev[10]),
    .regulator_saturated(ev[11]), .current_out_of_range(ev[12]),
    .current_output_on(current_output_on), .ext_setpoint_range_select(ext_setpoint_range_select),
    .external_enable_select(external_enable_select), .ext_setpoint_use(ext_setpoint_use),
    .image_download_allowed(image_download_allowed)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : check

  // Status while on and software-enabled: bit 3 only with no fault
  function automatic logic [31:0] st_exp(input logic [31:0] fw);
    return (fw == 32'h0000_0000) ? 32'h0000_000D : 32'h0000_0005;
  endfunction : st_exp

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic cmd(input logic [2:0] c, input logic [31:0] w);
    cyc(1);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_wdata = w;
    cyc(1);
    cmd_valid = 1'b0;
    rd = resp_data;
    check("resp_valid", resp_valid, 64'h1);
  endtask : cmd

  task automatic rdchk(input logic [31:0] ef, input logic [31:0] es);
    cmd(CMD_READ_STATUS, $urandom);
    check("status_rd", rd, {32'h0, es});
    cmd(CMD_READ_FAULT, $urandom);
    check("fault_rd", rd, {32'h0, ef});
    cmd(CMD_COMBINED_WORD_READ, $urandom);
    check("combined", rd, {ef, es});
  endtask : rdchk

  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run is well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  initial begin
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_code = 3'h0;
    cmd_wdata = 32'h0000_0000;
    ev = '0;
    ext_enable_pin = 1'b0;
    selftest_active = 1'b0;
    cooling_down = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    pers = 32'h0000_0000;
    wd = $urandom(4);
    cyc(8);
    arst_n = 1'b1;
    rdchk(32'h0000_0000, 32'h0000_0009);
    for (int c = 5; c < 8; c++) begin
      cmd(3'(c), $urandom);
      check("unused_code", rd, '0);
    end
    // Bits 2 and 6 kept low so bit 1 is writable
    wd = $urandom & 32'hFFFF_FFBB;
    cmd(CMD_WRITE_STATUS, wd);
    check("status_wr", rd, {32'h0, (wd & 32'h0000_0097) | 32'h0000_0008});
    cyc(1);
    check("range_sel", ext_setpoint_range_select, wd[7]);
    check("setpoint_use", ext_setpoint_use, wd[1]);
    cmd(CMD_WRITE_STATUS, 32'h0000_0005);
    cyc(2);
    check("output_on", current_output_on, 64'h1);
    // Setpoint source frozen while enabled
    cmd(CMD_WRITE_STATUS, 32'h0000_0007);
    check("status_wr", rd, 64'hD);
    cyc(1);
    check("setpoint_use", ext_setpoint_use, 64'h0);
    for (int p = 0; p < 2; p++) begin
      selftest_active = p[0];
      for (int i = 0; i < 13; i++) begin
        f = ((i == 6 || i == 7) && p == 0) ? 32'h0 : 32'h1 << fmap[i];
        ev[i] = 1'b1;
        cyc(1 + $urandom_range(2));
        ev[i] = 1'b0;
        pers |= f & 32'h0000_00A0;
        cyc(2);
        check("output_on", current_output_on, (f | pers) == 0);
        check("download", image_download_allowed, !f[3]);
        rdchk(f | pers, st_exp(f | pers));
        check("fault_word", rd[63:32], f | pers);
        cmd(CMD_FAULT_CLEAR, $urandom);
        check("clear_resp", rd, '0);
        rdchk(pers, st_exp(pers));
      end
      if (p == 0) begin
        cooling_down = 1'b1;
        cyc(3);
        check("output_on", current_output_on, 64'h0);
        cmd(CMD_FAULT_CLEAR, 32'h0000_0000);
        rdchk(32'h0000_0400, 32'h0000_0005);
        cooling_down = 1'b0;
        cyc(2);
        rdchk(32'h0000_0000, 32'h0000_000D);
      end
    end
    cmd(CMD_WRITE_STATUS, 32'h0000_0045);
    check("status_wr", rd, 64'h41);
    cyc(1);
    check("ext_select", external_enable_select, 64'h1);
    ev[0] = 1'b1;
    cyc(1);
    ev[0] = 1'b0;
    ext_enable_pin = 1'b1;
    cyc(6);
    rdchk(pers, 32'h0000_0045);
    cmd(CMD_WRITE_STATUS, 32'h0000_0001);
    cmd(CMD_WRITE_STATUS, 32'h0000_0041);
    rdchk(pers | 32'h0000_2000, 32'h0000_0045);
    // Power cycle with the pin held high
    arst_n = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    cyc(6);
    rdchk(32'h0000_1000, 32'h0000_0001);
    end_sim();
  end
endmodule : testbench
`default_nettype wire
